// ==== bench/cel_capture_bench.sv ====
// self-checking bench for the error and level capture block
// assumes cel_pkg, cel_err_if, rtl and the panel model compiled first
`timescale 1ns/1ps
`default_nettype none
`include "cel_cfg.svh"
module cel_capture_bench;
    import cel_pkg::*;
    logic core_clk, sys_rst, powerOnRst, cmdDisableChecks, cmdEnableChecks, cmdResetMachCheck;
    logic loadOp, instrStart, qualWrite, addrLoad, addrStep, senseCtrlReg, senseLevel;
    logic senseImmediate, keyReq, forceReq, jumperReq, panelSysReset, panelForceRun;
    logic jumperNoCheck, machCheckIrq, checksDisabled, errTableWrite, senseValid, immValid;
    logic [7:0] procErrIn, storErrIn, instrQualifier, qualWriteData;
    logic machCheckDone;
    logic [1:0] senseSel;
    logic [63:0] xlatRegs, translationSet;
    cel_level_t curLevel;
    cel_addr_t addrLoadVal, nextInstrAddr;
    cel_byte_t levelByte, backupModeReg, qualifierReg, errTableLevel, senseData;
    cel_byte_t immProcErr, immStorErr;
    int n_errors = 0;
    int cmp_count = 0;
    logic [3:0] codeTab [7] = '{`CEL_LVL_MAIN, `CEL_LVL_INT1, `CEL_LVL_INT2, `CEL_LVL_INT3,
        `CEL_LVL_INT4, `CEL_LVL_INT5, `CEL_LVL_STEAL};

    cel_panel_model u_cel_panel_model (.core_clk(core_clk), .sys_rst(sys_rst),
        .keyReq(keyReq), .forceReq(forceReq), .jumperReq(jumperReq),
        .panelSysReset(panelSysReset), .panelForceRun(panelForceRun),
        .jumperNoCheck(jumperNoCheck));

    cel_capture u_cel_capture (.core_clk(core_clk), .sys_rst(sys_rst),
        .powerOnRst(powerOnRst), .panelSysReset(panelSysReset),
        .panelForceRun(panelForceRun), .jumperNoCheck(jumperNoCheck),
        .cmdDisableChecks(cmdDisableChecks), .cmdEnableChecks(cmdEnableChecks),
        .cmdResetMachCheck(cmdResetMachCheck), .loadOp(loadOp), .procErrIn(procErrIn),
        .storErrIn(storErrIn), .curLevel(curLevel), .machCheckDone(machCheckDone),
        .instrStart(instrStart), .instrQualifier(instrQualifier), .qualWrite(qualWrite),
        .qualWriteData(qualWriteData), .addrLoad(addrLoad), .addrLoadVal(addrLoadVal),
        .addrStep(addrStep), .xlatRegs(xlatRegs), .senseCtrlReg(senseCtrlReg),
        .senseLevel(senseLevel), .senseSel(senseSel), .senseImmediate(senseImmediate),
        .machCheckIrq(machCheckIrq), .checksDisabled(checksDisabled),
        .levelByte(levelByte), .backupModeReg(backupModeReg), .qualifierReg(qualifierReg),
        .nextInstrAddr(nextInstrAddr), .translationSet(translationSet),
        .errTableWrite(errTableWrite), .errTableLevel(errTableLevel),
        .senseData(senseData), .senseValid(senseValid), .immProcErr(immProcErr),
        .immStorErr(immStorErr), .immValid(immValid));

    initial begin
        core_clk = 1'b0;
        forever #2.5 core_clk = ~core_clk;
    end

    task automatic chk(input logic [63:0] got, input logic [63:0] exp, input string what);
        cmp_count++;
        if (got !== exp) begin
            n_errors++;
            $display("wrong value at %0t: %s got %h expected %h", $time, what, got, exp);
        end
    endtask

    task automatic close_out();
        $display("checks %0d, mismatches %0d", cmp_count, n_errors);
        if (n_errors == 0 && cmp_count > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask

    // immediate sense of both error bytes, answer one cycle later
    task automatic imm_sense(input cel_byte_t expP, input cel_byte_t expS);
        @(posedge core_clk) senseImmediate <= 1'b1;
        @(posedge core_clk) senseImmediate <= 1'b0;
        #1;
        chk(immValid, 1, "immediate valid");
        chk(immProcErr, expP, "processor byte");
        chk(immStorErr, expS, "storage byte");
    endtask

    // control register sense or level sense
    task automatic sense(input logic byLevel, input logic [1:0] sel, input cel_byte_t exp);
        @(posedge core_clk) begin
            senseLevel <= byLevel;
            senseCtrlReg <= ~byLevel;
            senseSel <= sel;
        end
        @(posedge core_clk) begin
            senseLevel <= 1'b0;
            senseCtrlReg <= 1'b0;
        end
        #1;
        chk(senseValid, 1, "sense valid");
        chk(senseData, exp, "sense data");
    endtask

    // one error, its capture, a load, then clearing by source i/2
    task automatic err_case(input int i);
        cel_byte_t pat;
        pat = 8'h01 << i;
        @(posedge core_clk) curLevel <= cel_level_t'(i + 1);
        @(posedge core_clk) begin
            if (i[0]) storErrIn <= pat;
            else procErrIn <= pat;
        end
        @(posedge core_clk) begin
            procErrIn <= 8'h00;
            storErrIn <= 8'h00;
        end
        #1;
        chk(errTableWrite, 1, "table write");
        chk(errTableLevel, {4'h0, codeTab[i + 1]}, "table level");
        @(posedge core_clk) loadOp <= 1'b1;
        #1;
        chk(machCheckIrq, 1, "machine check");
        chk(levelByte, {5'h01, codeTab[i + 1][2:0]}, "check level");
        @(posedge core_clk) loadOp <= 1'b0;
        imm_sense(i[0] ? 8'h00 : pat, i[0] ? pat : 8'h00);
        @(posedge core_clk) begin
            cmdResetMachCheck <= (i / 2 == 0);
            powerOnRst <= (i / 2 == 1);
            keyReq <= (i / 2 == 2);
        end
        @(posedge core_clk) begin
            cmdResetMachCheck <= 1'b0;
            powerOnRst <= 1'b0;
            keyReq <= 1'b0;
        end
        repeat (3) @(posedge core_clk);
        #1;
        chk(machCheckIrq, 0, "check cleared");
        imm_sense(8'h00, 8'h00);
    endtask

    initial begin
        #20000;
        n_errors++;
        close_out();
    end

    initial begin
        {sys_rst, powerOnRst, cmdDisableChecks, cmdEnableChecks, cmdResetMachCheck} = 5'h01 << 4;
        {loadOp, instrStart, qualWrite, addrLoad, addrStep, senseCtrlReg, senseLevel} = 7'h00;
        {senseImmediate, keyReq, forceReq, jumperReq, machCheckDone} = 5'h00;
        {procErrIn, storErrIn, instrQualifier, qualWriteData} = 32'h0000_0000;
        senseSel = 2'h0;
        xlatRegs = 64'h0;
        addrLoadVal = 16'h0000;
        curLevel = CEL_OP_MAIN;
        repeat (12) @(posedge core_clk);
        sys_rst <= 1'b0;
        #1;
        chk(backupModeReg, 8'h00, "backup mode");
        imm_sense(8'h00, 8'h00);
        for (int i = 0; i < 7; i++) begin
            @(posedge core_clk) curLevel <= cel_level_t'(i);
            #1;
            chk(levelByte, {4'h0, codeTab[i]}, "level code");
            sense(i[0], 2'h0, {4'h0, codeTab[i]});
        end
        for (int s = 1; s < 4; s++) sense(1'b0, s[1:0], 8'h00);
        $display("test levels done");
        for (int i = 0; i < 6; i++) err_case(i);
        $display("test errors done");
        @(posedge core_clk) cmdDisableChecks <= 1'b1;
        @(posedge core_clk) begin
            cmdDisableChecks <= 1'b0;
            procErrIn <= 8'h80;
        end
        @(posedge core_clk) procErrIn <= 8'h00;
        repeat (3) @(posedge core_clk);
        #1;
        chk(checksDisabled, 1, "disabled by command");
        chk(machCheckIrq, 0, "no check when disabled");
        @(posedge core_clk) begin
            cmdEnableChecks <= 1'b1;
            forceReq <= 1'b1;
        end
        @(posedge core_clk) cmdEnableChecks <= 1'b0;
        @(posedge core_clk) storErrIn <= 8'h40;
        @(posedge core_clk) storErrIn <= 8'h00;
        repeat (3) @(posedge core_clk);
        #1;
        chk(checksDisabled, 1, "disabled by force run");
        chk(machCheckIrq, 0, "no storage check");
        imm_sense(8'h80, 8'h40);
        @(posedge core_clk) begin
            forceReq <= 1'b0;
            jumperReq <= 1'b1;
        end
        repeat (2) @(posedge core_clk);
        #1;
        chk(checksDisabled, 1, "disabled by jumper");
        @(posedge core_clk) cmdResetMachCheck <= 1'b1;
        @(posedge core_clk) begin
            cmdResetMachCheck <= 1'b0;
            jumperReq <= 1'b0;
        end
        repeat (3) @(posedge core_clk);
        #1;
        chk(checksDisabled, 0, "checks enabled");
        chk(machCheckIrq, 0, "stale flags cleared");
        @(posedge core_clk) begin
            procErrIn <= 8'h04;
            cmdResetMachCheck <= 1'b1;
        end
        @(posedge core_clk) begin
            procErrIn <= 8'h00;
            cmdResetMachCheck <= 1'b0;
        end
        imm_sense(8'h04, 8'h00);
        chk(machCheckIrq, 1, "new error beats clear");
        @(posedge core_clk) cmdDisableChecks <= 1'b1;
        @(posedge core_clk) begin
            cmdDisableChecks <= 1'b0;
            machCheckDone <= 1'b1;
        end
        @(posedge core_clk) machCheckDone <= 1'b0;
        #1;
        chk(machCheckIrq, 0, "check left on done");
        $display("test disable and priority done");
        @(posedge core_clk) begin
            instrStart <= 1'b1;
            instrQualifier <= 8'hA5;
            addrLoad <= 1'b1;
            addrLoadVal <= 16'h1234;
            xlatRegs <= 64'h0807_0605_0403_0201;
        end
        @(posedge core_clk) begin
            instrStart <= 1'b0;
            qualWrite <= 1'b1;
            qualWriteData <= 8'h3C;
            addrLoad <= 1'b0;
            addrStep <= 1'b1;
        end
        #1;
        chk(qualifierReg, 8'hA5, "qualifier load");
        chk(nextInstrAddr, 16'h1234, "address load");
        @(posedge core_clk) qualWrite <= 1'b0;
        #1;
        chk(qualifierReg, 8'h3C, "qualifier change");
        @(posedge core_clk) addrStep <= 1'b0;
        #1;
        chk(nextInstrAddr, 16'h1236, "address step");
        chk(translationSet, 64'h0102_0304_0506_0000, "translation set");
        $display("test registers done");
        close_out();
    end
endmodule // cel_capture_bench
`default_nettype wire

// ==== bench/cel_panel_model.sv ====
// control panel stand-in: reset key, force run key and check jumper
// assumes one core clock; bench raises requests for one cycle or as levels
`timescale 1ns/1ps
`default_nettype none
module cel_panel_model (
    input wire logic core_clk,
    input wire logic sys_rst,
    input wire logic keyReq,
    input wire logic forceReq,
    input wire logic jumperReq,
    output logic panelSysReset,
    output logic panelForceRun,
    output logic jumperNoCheck
);
    logic key_q, key_d, force_q, force_d, jumper_q, jumper_d;
    always_comb begin
        key_d = keyReq & ~key_q;
        force_d = forceReq;
        jumper_d = jumperReq;
    end
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            key_q <= 1'b0;
            force_q <= 1'b0;
            jumper_q <= 1'b0;
        end else begin
            key_q <= key_d;
            force_q <= force_d;
            jumper_q <= jumper_d;
        end
    end
    assign panelSysReset = key_q;
    assign panelForceRun = force_q;
    assign jumperNoCheck = jumper_q;
endmodule // cel_panel_model
`default_nettype wire

// ==== inc/cel_cfg.svh ====
// constants for the error and level capture block
// assumes inclusion by bare name from package and rtl files
`ifndef CEL_CFG_SVH
`define CEL_CFG_SVH
`define CEL_BYTE_W 8
`define CEL_ADDR_W 16
`define CEL_XLAT_REGS 8
`define CEL_XLAT_W 8
`define CEL_BACKUP_MODE_VAL 8'h00
`define CEL_LVL_RST 8'h0C
`define CEL_LVL_MCHK_BIT 4
`define CEL_ERR_RST 8'h00
`define CEL_ADDR_RST 16'h0000
`define CEL_LVL_MACHINE 4'h8
`define CEL_LVL_INT1 4'h1
`define CEL_LVL_INT2 4'h2
`define CEL_LVL_INT3 4'h3
`define CEL_LVL_INT4 4'h4
`define CEL_LVL_INT5 4'h5
`define CEL_LVL_MAIN 4'h6
`define CEL_LVL_STEAL 4'h7
`define CEL_SEL_LEVEL 2'h0
`define CEL_SEL_PROC_ERR 2'h1
`define CEL_SEL_STOR_ERR 2'h2
`define CEL_SEL_BACKUP 2'h3
`endif

// ==== inc/cel_err_if.sv ====
// carries one error byte between capture and its owner
// assumes a single core clock
`timescale 1ns/1ps
`default_nettype none
interface cel_err_if;
    import cel_pkg::*;
    cel_byte_t setBits;
    logic clear;
    cel_byte_t value;
    logic any;
    modport owner (output setBits, output clear, input value, input any);
    modport keeper (input setBits, input clear, output value, output any);
endinterface
`default_nettype wire

// ==== inc/cel_pkg.sv ====
// types for the error and level capture block
// assumes cel_cfg.svh on the include path
`include "cel_cfg.svh"
package cel_pkg;
    typedef enum logic [2:0] {
        CEL_OP_MAIN,
        CEL_OP_INT1,
        CEL_OP_INT2,
        CEL_OP_INT3,
        CEL_OP_INT4,
        CEL_OP_INT5,
        CEL_OP_STEAL
    } cel_level_t;
    typedef logic [`CEL_BYTE_W-1:0] cel_byte_t;
    typedef logic [`CEL_ADDR_W-1:0] cel_addr_t;
endpackage

// ==== rtl/cel_capture.sv ====
// error, level and status capture of the control store processor
// assumes one synchronous clock; microcode drives strobes for one cycle
// Notes on behaviour
// - qualifier register loads at instruction start, may change while running.
// - backup mode register always reads zero.
// - translation set read as one field, direct first, two unused slots last.
// - address register always holds next instruction address.
// - on any error the level byte is copied to the error table.
// - level byte readable by control-register sense or level sense.
// - level code only in bits 0 to 3, upper bits zero.
// - in machine check the low three bits keep the interrupted level.
// - processor errors raise machine check unless checks disabled.
// - storage errors are flagged and raise machine check unless disabled.
// - error bits set even while checks are disabled.
// - processor error byte cleared by reset command, power-on or system reset.
// - storage error byte cleared by the same three sources.
// - processor error byte survives a load.
// - storage error byte survives a load.
// - immediate sense returns both error bytes.
`timescale 1ns/1ps
`default_nettype none
`include "cel_cfg.svh"
module cel_capture #(
    parameter int XLAT_REGS = `CEL_XLAT_REGS,
    parameter int XLAT_W = `CEL_XLAT_W
) (
    input wire logic core_clk,
    input wire logic sys_rst,
    input wire logic powerOnRst,
    input wire logic panelSysReset,
    input wire logic panelForceRun,
    input wire logic jumperNoCheck,
    input wire logic cmdDisableChecks,
    input wire logic cmdEnableChecks,
    input wire logic cmdResetMachCheck,
    input wire logic loadOp,
    input wire logic [7:0] procErrIn,
    input wire logic [7:0] storErrIn,
    input wire cel_pkg::cel_level_t curLevel,
    input wire logic machCheckDone,
    input wire logic instrStart,
    input wire logic [7:0] instrQualifier,
    input wire logic qualWrite,
    input wire logic [7:0] qualWriteData,
    input wire logic addrLoad,
    input wire cel_pkg::cel_addr_t addrLoadVal,
    input wire logic addrStep,
    input wire logic [XLAT_REGS*XLAT_W-1:0] xlatRegs,
    input wire logic senseCtrlReg,
    input wire logic senseLevel,
    input wire logic [1:0] senseSel,
    input wire logic senseImmediate,
    output logic machCheckIrq,
    output logic checksDisabled,
    output cel_pkg::cel_byte_t levelByte,
    output cel_pkg::cel_byte_t backupModeReg,
    output cel_pkg::cel_byte_t qualifierReg,
    output cel_pkg::cel_addr_t nextInstrAddr,
    output logic [XLAT_REGS*XLAT_W-1:0] translationSet,
    output logic errTableWrite,
    output cel_pkg::cel_byte_t errTableLevel,
    output cel_pkg::cel_byte_t senseData,
    output logic senseValid,
    output cel_pkg::cel_byte_t immProcErr,
    output cel_pkg::cel_byte_t immStorErr,
    output logic immValid
);
    import cel_pkg::*;
    cel_err_if procErr();
    cel_err_if storErr();
    logic [3:0] curCode;
    logic clearErr;
    logic anyErr;
    logic disQ;
    logic disD;
    logic mchkQ;
    logic mchkD;
    logic [2:0] savedQ;
    logic [2:0] savedD;
    cel_byte_t qualQ;
    cel_byte_t qualD;
    cel_addr_t addrQ;
    cel_addr_t addrD;
    cel_byte_t lvlByte;
    cel_byte_t senseQ;
    cel_byte_t senseD;
    logic senseVQ;
    logic senseVD;
    cel_byte_t immPQ;
    cel_byte_t immSQ;
    logic immVQ;
    logic tblWQ;
    cel_byte_t tblLQ;
    logic [XLAT_REGS*XLAT_W-1:0] xlatQ;

    cel_level_code levelCode (
        .level(curLevel),
        .code(curCode)
    );
    // load leaves both bytes alone; only these sources clear
    assign clearErr = cmdResetMachCheck | powerOnRst | panelSysReset;
    assign procErr.setBits = procErrIn;
    assign procErr.clear = clearErr;
    assign storErr.setBits = storErrIn;
    assign storErr.clear = clearErr;
    cel_err_byte procErrByte (
        .core_clk(core_clk),
        .sys_rst(sys_rst),
        .err(procErr.keeper)
    );
    cel_err_byte storErrByte (
        .core_clk(core_clk),
        .sys_rst(sys_rst),
        .err(storErr.keeper)
    );
    assign anyErr = (|procErrIn) | (|storErrIn);

    // check disable: registered command latch plus panel key and jumper
    always_comb begin
        disD = disQ;
        if (cmdEnableChecks) begin
            disD = 1'b0;
        end
        if (cmdDisableChecks) begin
            disD = 1'b1;
        end
    end
    assign checksDisabled = disQ | panelForceRun | jumperNoCheck;
    assign machCheckIrq = mchkQ;

    // machine check state and the level saved on entry
    always_comb begin
        mchkD = mchkQ;
        savedD = savedQ;
        if (clearErr || machCheckDone) begin
            mchkD = 1'b0;
        end
        // a clear in flight beats the stale byte; a new error re-raises next cycle
        if (!checksDisabled && !clearErr && (procErr.any || storErr.any)) begin
            mchkD = 1'b1;
        end
        if (!mchkQ && mchkD) begin
            savedD = curCode[2:0];
        end
    end

    always_comb begin
        if (mchkQ) begin
            lvlByte = {4'h0, 1'b1, savedQ};
        end else begin
            lvlByte = {4'h0, curCode};
        end
    end
    assign levelByte = lvlByte;
    assign backupModeReg = `CEL_BACKUP_MODE_VAL;

    // qualifier register and next-instruction address
    always_comb begin
        qualD = qualQ;
        if (instrStart) begin
            qualD = instrQualifier;
        end else if (qualWrite) begin
            qualD = qualWriteData;
        end
        addrD = addrQ;
        if (addrLoad) begin
            addrD = addrLoadVal;
        end else if (addrStep) begin
            addrD = addrQ + 16'h0001;
        end
    end

    // sense answers, one cycle after the strobe
    always_comb begin
        senseD = senseQ;
        senseVD = 1'b0;
        if (senseLevel) begin
            senseD = lvlByte;
            senseVD = 1'b1;
        end else if (senseCtrlReg) begin
            senseVD = 1'b1;
            case (senseSel)
                `CEL_SEL_LEVEL: senseD = lvlByte;
                `CEL_SEL_PROC_ERR: senseD = procErr.value;
                `CEL_SEL_STOR_ERR: senseD = storErr.value;
                `CEL_SEL_BACKUP: senseD = `CEL_BACKUP_MODE_VAL;
                default: senseD = 8'h00;
            endcase
        end
    end

    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            disQ <= 1'b0;
            mchkQ <= 1'b0;
            savedQ <= 3'h0;
            qualQ <= 8'h00;
            addrQ <= `CEL_ADDR_RST;
            senseQ <= 8'h00;
            senseVQ <= 1'b0;
            immPQ <= 8'h00;
            immSQ <= 8'h00;
            immVQ <= 1'b0;
            tblWQ <= 1'b0;
            tblLQ <= 8'h00;
            xlatQ <= '0;
        end else begin
            disQ <= disD;
            mchkQ <= mchkD;
            savedQ <= savedD;
            qualQ <= qualD;
            addrQ <= addrD;
            senseQ <= senseD;
            senseVQ <= senseVD;
            immVQ <= senseImmediate;
            if (senseImmediate) begin
                immPQ <= procErr.value;
                immSQ <= storErr.value;
            end
            tblWQ <= anyErr;
            if (anyErr) begin
                tblLQ <= lvlByte;
            end
            xlatQ <= xlatRegs;
        end
    end

    // translation set: register 0 (direct) leftmost, unused slots read zero
    genvar gi;
    generate
        for (gi = 0; gi < XLAT_REGS; gi++) begin : gXlat
            if (gi < 6) begin : gUsed
                assign translationSet[(XLAT_REGS-gi)*XLAT_W-1 -: XLAT_W] =
                    xlatQ[gi*XLAT_W +: XLAT_W];
            end else begin : gUnused
                assign translationSet[(XLAT_REGS-gi)*XLAT_W-1 -: XLAT_W] = '0;
            end
        end
    endgenerate

    assign qualifierReg = qualQ;
    assign nextInstrAddr = addrQ;
    assign errTableWrite = tblWQ;
    assign errTableLevel = tblLQ;
    assign senseData = senseQ;
    assign senseValid = senseVQ;
    assign immProcErr = immPQ;
    assign immStorErr = immSQ;
    assign immValid = immVQ;

    property p_bmr_zero;
        @(posedge core_clk) backupModeReg == 8'h00;
    endproperty
    a_bmr_zero: assert property (p_bmr_zero)
        else $error("backup mode reg nonzero");
    property p_lvl_hi;
        @(posedge core_clk) disable iff (sys_rst) levelByte[7:4] == 4'h0;
    endproperty
    a_lvl_hi: assert property (p_lvl_hi)
        else $error("level byte upper bits set");
    property p_qual;
        @(posedge core_clk) disable iff (sys_rst)
        instrStart |=> qualifierReg == $past(instrQualifier);
    endproperty
    a_qual: assert property (p_qual)
        else $error("qualifier not loaded");
    property p_addr;
        @(posedge core_clk) disable iff (sys_rst)
        (addrStep && !addrLoad) |=> nextInstrAddr == $past(nextInstrAddr) + 16'h0001;
    endproperty
    a_addr: assert property (p_addr)
        else $error("address not stepped");
    property p_tbl;
        @(posedge core_clk) disable iff (sys_rst)
        anyErr |=> errTableWrite && errTableLevel == $past(levelByte);
    endproperty
    a_tbl: assert property (p_tbl)
        else $error("level not captured");
    property p_sense;
        @(posedge core_clk) disable iff (sys_rst)
        senseLevel |=> senseValid && senseData == $past(levelByte);
    endproperty
    a_sense: assert property (p_sense)
        else $error("level sense wrong");
    property p_irq;
        @(posedge core_clk) disable iff (sys_rst)
        (!checksDisabled && |procErrIn) |->
            ##2 (machCheckIrq || $past(clearErr) || $past(machCheckDone));
    endproperty
    a_irq: assert property (p_irq)
        else $error("machine check missed");
    property p_dis;
        @(posedge core_clk) disable iff (sys_rst)
        (checksDisabled && !machCheckIrq) |=> !machCheckIrq;
    endproperty
    a_dis: assert property (p_dis)
        else $error("machine check while disabled");
    property p_clr;
        @(posedge core_clk) disable iff (sys_rst)
        (clearErr && procErrIn == 8'h00 && storErrIn == 8'h00) |=>
            !machCheckIrq && procErr.value == 8'h00 && storErr.value == 8'h00;
    endproperty
    a_clr: assert property (p_clr)
        else $error("error byte not cleared");
    property p_load;
        @(posedge core_clk) disable iff (sys_rst)
        (loadOp && !clearErr) |=>
            (procErr.value & $past(procErr.value)) == $past(procErr.value) &&
            (storErr.value & $past(storErr.value)) == $past(storErr.value);
    endproperty
    a_load: assert property (p_load)
        else $error("load cleared error byte");
    property p_imm;
        @(posedge core_clk) disable iff (sys_rst)
        senseImmediate |=> immValid && immStorErr == $past(storErr.value) &&
            immProcErr == $past(procErr.value);
    endproperty
    a_imm: assert property (p_imm)
        else $error("immediate sense wrong");
    property p_mchk_lvl;
        @(posedge core_clk) disable iff (sys_rst)
        $rose(machCheckIrq) |-> levelByte[3] && levelByte[2:0] == $past(curCode[2:0]);
    endproperty
    a_mchk_lvl: assert property (p_mchk_lvl)
        else $error("machine check level wrong");
    c_mchk: cover property (@(posedge core_clk) $rose(machCheckIrq));
    c_clr: cover property (@(posedge core_clk) machCheckIrq ##1 clearErr ##1 !machCheckIrq);
    c_dis: cover property (@(posedge core_clk) checksDisabled && |procErrIn);
endmodule // cel_capture
`default_nettype wire

// ==== rtl/cel_err_byte.sv ====
// one sticky error byte, set wins over clear
// assumes synchronous reset on core_clk
`timescale 1ns/1ps
`default_nettype none
`include "cel_cfg.svh"
module cel_err_byte (
    input wire logic core_clk,
    input wire logic sys_rst,
    cel_err_if.keeper err
);
    import cel_pkg::*;
    cel_byte_t errQ;
    cel_byte_t errD;
    always_comb begin
        errD = errQ;
        if (err.clear) begin
            errD = `CEL_ERR_RST;
        end
        errD = errD | err.setBits;
    end
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            errQ <= `CEL_ERR_RST;
        end else begin
            errQ <= errD;
        end
    end
    assign err.value = errQ;
    assign err.any = |errQ;
    property p_set_sticks;
        @(posedge core_clk) disable iff (sys_rst)
        (|err.setBits) |=> ((errQ & $past(err.setBits)) == $past(err.setBits));
    endproperty
    a_set_sticks: assert property (p_set_sticks)
        else $error("error bit lost");
endmodule // cel_err_byte

// ==== rtl/cel_level_code.sv ====
// maps an operation level onto its four-bit code
// assumes purely combinational use
`timescale 1ns/1ps
`default_nettype none
`include "cel_cfg.svh"
module cel_level_code (
    input wire cel_pkg::cel_level_t level,
    output logic [3:0] code
);
    import cel_pkg::*;
    always_comb begin
        case (level)
            CEL_OP_INT1: code = `CEL_LVL_INT1;
            CEL_OP_INT2: code = `CEL_LVL_INT2;
            CEL_OP_INT3: code = `CEL_LVL_INT3;
            CEL_OP_INT4: code = `CEL_LVL_INT4;
            CEL_OP_INT5: code = `CEL_LVL_INT5;
            CEL_OP_STEAL: code = `CEL_LVL_STEAL;
            default: code = `CEL_LVL_MAIN;
        endcase
    end
endmodule // cel_level_code
